// *** rtl/star_bank.sv ***
`timescale 1ns/10ps
module star_bank
    import star_pkg::*;
(
    input  wire logic        clock_in,        // core clock
    input  wire logic        rst_in,          // sync reset, high
    input  wire logic        req_valid_in,    // register access request
    input  wire logic        req_write_in,    // 1 write, 0 read
    input  wire logic [1:0]  req_op0_in,      // encoding op0
    input  wire logic [2:0]  req_op1_in,      // encoding op1
    input  wire logic [3:0]  req_crn_in,      // encoding crn
    input  wire logic [3:0]  req_crm_in,      // encoding crm
    input  wire logic [2:0]  req_op2_in,      // encoding op2
    input  wire logic [63:0] req_wdata_in,    // write data
    input  wire logic [1:0]  cur_level_in,    // current exception level
    input  wire logic        nonsecure_state_bit_in,    // security state
    input  wire logic        general_trap_select_in,    // general trap
    input  wire logic        host_hypervisor_select_in, // no effect here
    input  wire logic        aux_access_ctrl_level2_in, // bit0 level2 gate
    input  wire logic        aux_access_ctrl_level3_in, // bit0 level3 gate
    input  wire logic        fp_insn_in,      // instruction uses fp regs
    output logic             resp_valid_out,  // access answered
    output logic [63:0]      resp_rdata_out,  // read data
    output logic             resp_fault_out,  // synchronous exception
    output logic             resp_hit_out,    // encoding belongs here
    output logic             fp_trap_out,     // trap fp insn to el3
    output logic             fp_vector_trap_bit_out // trap bit state
);
    import star_pkg::*;

    star_acc_if acc ();                      // checker link
    star_sel_t  sel;                         // decoded register

    logic        fp_trap_r;                  // trap bit flop
    logic        fp_trap_nxt;                // next trap bit
    logic [63:0] aux_r   [STAR_AUX_CNT];     // aux registers, one copy
    logic [63:0] aux_nxt [STAR_AUX_CNT];     // next aux values
    logic        valid_r, valid_nxt;         // answer strobe
    logic        fault_r, fault_nxt;         // exception flag
    logic        hit_r,   hit_nxt;           // decode hit flag
    logic [63:0] rdata_r, rdata_nxt;         // read data flop
    logic [63:0] rd_mux;                     // selected read value

    // request classes after the permission check
    // at most one of deny, wr_ok and rd_ok is high in a cycle
    logic        claimed;                    // decodes into this bank
    logic        deny;                       // claimed but refused
    logic        wr_ok;                      // permitted write
    logic        rd_ok;                      // permitted read

    // encoding decode, shared by read and write paths
    function automatic star_sel_t decode(input logic [1:0] op0,
                                         input logic [2:0] op1,
                                         input logic [3:0] crn,
                                         input logic [3:0] crm,
                                         input logic [2:0] op2);
        star_sel_t s;
        s = STAR_SEL_NONE;
        if (op0 == STAR_OP0_AUX && op1 == STAR_OP1_AUX
            && crn == STAR_CRN_AUX) begin
            if (crm == STAR_CRM_AUX_LOW) begin
                case (op2)
                    STAR_OP2_ONE:   s = STAR_SEL_ONE;
                    STAR_OP2_TWO:   s = STAR_SEL_TWO;
                    STAR_OP2_THREE: s = STAR_SEL_THREE;
                    default:        s = STAR_SEL_NONE;
                endcase
            end else if (crm == STAR_CRM_AUX_FIVE
                         && op2 == STAR_OP2_FIVE) begin
                s = STAR_SEL_FIVE;
            end
        end else if (op0 == STAR_OP0_TRAP && op1 == STAR_OP1_TRAP
                     && crn == STAR_CRN_TRAP && crm == STAR_CRM_TRAP
                     && op2 == STAR_OP2_TRAP) begin
            s = STAR_SEL_TRAP;
        end
        return s;
    endfunction

    // array slot of an aux select
    function automatic int slot(input star_sel_t s);
        case (s)
            STAR_SEL_ONE:   return 0;
            STAR_SEL_TWO:   return 1;
            STAR_SEL_THREE: return 2;
            default:        return 3;
        endcase
    endfunction

    // 32-bit trap image; only the fp/vector bit is live
    // the trace trap position is not built and always reads zero
    function automatic logic [31:0] trap_image(input logic trap_bit);
        logic [31:0] img;                    // image under construction
        img                   = STAR_TRAP_RESET; // other fields idle
        img[STAR_TRACE_POS]   = 1'b0;        // trace trap not built
        img[STAR_FP_TRAP_POS] = trap_bit;
        return img;
    endfunction

    assign sel = decode(req_op0_in, req_op1_in, req_crn_in,
                        req_crm_in, req_op2_in);

    // host hypervisor select has no say over this bank
    // feed the checker; state bit is not used to pick a copy
    assign acc.level     = cur_level_in;
    assign acc.nonsecure = nonsecure_state_bit_in;
    assign acc.gen_trap  = general_trap_select_in;
    assign acc.gate_l2   = aux_access_ctrl_level2_in;
    assign acc.gate_l3   = aux_access_ctrl_level3_in;
    assign acc.sel       = sel;
    assign acc.is_write  = req_write_in;

    star_access_check u_check (
        .acc (acc.check)
    );

    // read mux; aux words whole, trap register as its 32-bit image
    // encodings outside the bank read as zero
    always_comb begin
        rd_mux = 64'h0;                      // default for misses
        case (sel)
            STAR_SEL_ONE, STAR_SEL_TWO,
            STAR_SEL_THREE, STAR_SEL_FIVE: rd_mux = aux_r[slot(sel)];
            STAR_SEL_TRAP: rd_mux = {32'h0, trap_image(fp_trap_r)};
            default: rd_mux = 64'h0;
        endcase
    end

    // request classes; a claimed request decodes to this bank
    // a refused access must not reach any state below
    assign claimed = req_valid_in && (sel != STAR_SEL_NONE);
    assign deny    = claimed && !acc.allow;
    assign wr_ok   = claimed && acc.allow && req_write_in;
    assign rd_ok   = claimed && acc.allow && !req_write_in;

    // trap bit next value
    always_comb begin
        fp_trap_nxt = fp_trap_r;               // hold by default
        // only a permitted write of the trap register moves it
        if (wr_ok && sel == STAR_SEL_TRAP) begin
            fp_trap_nxt = req_wdata_in[STAR_FP_TRAP_POS];
        end
    end

    // trap bit register, clear after reset
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            fp_trap_r <= STAR_TRAP_RESET[STAR_FP_TRAP_POS];
        end else begin
            fp_trap_r <= fp_trap_nxt;          // take next value
        end
    end

    // one aux register per slot, one copy for both states
    // slot order: one, two, three, five
    for (genvar g = 0; g < STAR_AUX_CNT; g++) begin : g_aux
        // next value of this slot; writes replace the whole word
        always_comb begin
            aux_nxt[g] = aux_r[g];             // hold by default
            // trap register writes never land in a slot
            if (wr_ok && sel != STAR_SEL_TRAP && slot(sel) == g) begin
                aux_nxt[g] = req_wdata_in;
            end
        end

        // register of this slot
        always_ff @(posedge clock_in) begin
            if (rst_in) begin
                aux_r[g] <= STAR_AUX_RESET;    // cleared on reset
            end else begin
                aux_r[g] <= aux_nxt[g];        // take next value
            end
        end
    end

    // answer: every request gets one strobe, misses included
    // data only on a permitted read, so a fault leaks nothing
    always_comb begin
        valid_nxt = req_valid_in;              // one per request
        hit_nxt   = claimed;
        fault_nxt = deny;
        rdata_nxt = rd_ok ? rd_mux : 64'h0;    // zero unless read
    end

    // answer registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            // outputs quiet while reset is held
            valid_r <= 1'b0;
            fault_r <= 1'b0;
            hit_r   <= 1'b0;
            rdata_r <= 64'h0;
        end else begin
            valid_r <= valid_nxt;
            fault_r <= fault_nxt;
            hit_r   <= hit_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // trap output is combinational so the instruction in flight sees
    // the bit as last written; no level, state or mode input takes
    // part, so no exception level or security state is exempt
    assign fp_trap_out            = fp_trap_r && fp_insn_in;
    assign fp_vector_trap_bit_out = fp_trap_r;

    // answer outputs straight from their flops
    assign resp_valid_out         = valid_r;
    assign resp_fault_out         = fault_r;
    assign resp_hit_out           = hit_r;
    assign resp_rdata_out         = rdata_r;
endmodule // star_bank

// *** rtl/star_pkg.sv ***
package star_pkg;
    // system register encoding fields
    localparam logic [1:0] STAR_OP0_AUX      = 2'h3;   // op0 = 11
    localparam logic [2:0] STAR_OP1_AUX      = 3'h0;   // op1 = 000
    localparam logic [3:0] STAR_CRN_AUX      = 4'hf;   // crn = 1111
    localparam logic [3:0] STAR_CRM_AUX_LOW  = 4'h1;   // crm for one..three
    localparam logic [3:0] STAR_CRM_AUX_FIVE = 4'h9;   // crm for five
    localparam logic [2:0] STAR_OP2_ONE      = 3'h0;   // op2 of register one
    localparam logic [2:0] STAR_OP2_TWO      = 3'h1;   // op2 of register two
    localparam logic [2:0] STAR_OP2_THREE    = 3'h2;   // op2 of register three
    localparam logic [2:0] STAR_OP2_FIVE     = 3'h0;   // op2 of register five
    // trap control encoding (own choice, outside aux space)
    localparam logic [1:0] STAR_OP0_TRAP     = 2'h3;   // op0 of trap register
    localparam logic [2:0] STAR_OP1_TRAP     = 3'h6;   // op1 of trap register
    localparam logic [3:0] STAR_CRN_TRAP     = 4'h1;   // crn of trap register
    localparam logic [3:0] STAR_CRM_TRAP     = 4'h1;   // crm of trap register
    localparam logic [2:0] STAR_OP2_TRAP     = 3'h2;   // op2 of trap register
    // trap register layout
    localparam int         STAR_FP_TRAP_POS  = 10;     // fp/vector trap bit
    localparam int         STAR_TRACE_POS    = 20;     // trace trap, reads 0
    localparam logic [31:0] STAR_TRAP_RESET  = 32'h0000_0000; // reset value
    localparam logic [63:0] STAR_AUX_RESET   = 64'h0; // aux reset value
    localparam int         STAR_AUX_CNT      = 4;      // aux registers
    // exception levels
    localparam logic [1:0] STAR_EL0 = 2'h0;            // user level
    localparam logic [1:0] STAR_EL1 = 2'h1;            // kernel level
    localparam logic [1:0] STAR_EL2 = 2'h2;            // hypervisor level
    localparam logic [1:0] STAR_EL3 = 2'h3;            // monitor level
    // decoded register select
    typedef enum logic [2:0] {
        STAR_SEL_NONE,
        STAR_SEL_ONE,
        STAR_SEL_TWO,
        STAR_SEL_THREE,
        STAR_SEL_FIVE,
        STAR_SEL_TRAP
    } star_sel_t;
endpackage

// *** rtl/star_acc_if.sv ***
`timescale 1ns/10ps
// access context passed from the bank to its permission checker
interface star_acc_if;
    logic [1:0] level;        // current exception level
    logic       nonsecure;    // nonsecure state bit
    logic       gen_trap;     // general trap select
    logic       gate_l2;      // level2 write gate bit
    logic       gate_l3;      // level3 write gate bit
    logic [2:0] sel;          // decoded register select
    logic       is_write;     // access is a write
    logic       allow;        // access permitted
    modport bank (output level, nonsecure, gen_trap, gate_l2, gate_l3,
                  sel, is_write, input allow);
    modport check (input level, nonsecure, gen_trap, gate_l2, gate_l3,
                   sel, is_write, output allow);
endinterface

// *** rtl/star_access_check.sv ***
`timescale 1ns/10ps
// permission check for one system register access
module star_access_check
    import star_pkg::*;
(
    star_acc_if.check acc  // access context and verdict
);
    logic level_ok;        // level may touch aux registers
    logic gated;           // register under write gate
    logic gate_open;       // write gate lets write through

    // level table for aux registers
    always_comb begin
        case (acc.level)
            STAR_EL0: level_ok = 1'b0;
            STAR_EL1: level_ok = !(acc.nonsecure && acc.gen_trap);
            STAR_EL2: level_ok = acc.nonsecure;
            STAR_EL3: level_ok = 1'b1;
            default:  level_ok = 1'b0;
        endcase
    end

    // registers two, three and five carry the write gate
    assign gated = (acc.sel == STAR_SEL_TWO) || (acc.sel == STAR_SEL_THREE)
                 || (acc.sel == STAR_SEL_FIVE);
    // el1 needs both gate bits, el2 needs the level3 one
    always_comb begin
        case (acc.level)
            STAR_EL1: gate_open = acc.gate_l2 && acc.gate_l3;
            STAR_EL2: gate_open = acc.gate_l3;
            default:  gate_open = 1'b1;
        endcase
    end

    // final verdict
    always_comb begin
        if (acc.sel == STAR_SEL_TRAP) begin
            acc.allow = (acc.level == STAR_EL3);  // trap reg only at el3
        end else if (acc.sel == STAR_SEL_NONE) begin
            acc.allow = 1'b0;                     // not in this bank
        end else begin
            acc.allow = level_ok && !(acc.is_write && gated && !gate_open);
        end
    end
endmodule // star_access_check

// *** bench/star_core_model.sv ***
`timescale 1ns/10ps
// pipeline side: one system register access per call, back to back
module star_core_model (
    input  wire logic        clock_in,  // core clock
    output logic             valid_out, // request strobe
    output logic             write_out, // 1 write, 0 read
    output logic [15:0]      enc_out,   // op0,op1,crn,crm,op2
    output logic [63:0]      wdata_out  // write data
);
    // hold the request through its taking edge; reads and writes alike
    task automatic issue(input bit w, input logic [15:0] e,
                         input logic [63:0] d);
        valid_out = 1'b1;
        write_out = w;
        enc_out   = e;
        wdata_out = d;
        @(posedge clock_in);
        #1;
    endtask
    // release the request; released lines carry inverted junk
    task automatic idle();
        valid_out = 1'b0;
        write_out = ~write_out;
        enc_out   = ~enc_out;
        wdata_out = ~wdata_out;
        @(posedge clock_in);
        #1;
    endtask
    // quiet bus at time zero
    initial begin
        valid_out = 1'b0;
        write_out = 1'b0;
        enc_out   = 16'h0;
        wdata_out = 64'h0;
    end
endmodule // star_core_model

// *** bench/star_bank_assertions.sv ***
`timescale 1ns/10ps
// port-level checker of the register bank
module star_bank_assertions
    import star_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        req_valid_in,
    input wire logic        req_write_in,
    input wire logic [1:0]  req_op0_in,
    input wire logic [2:0]  req_op1_in,
    input wire logic [3:0]  req_crn_in,
    input wire logic [3:0]  req_crm_in,
    input wire logic [2:0]  req_op2_in,
    input wire logic [1:0]  cur_level_in,
    input wire logic        aux_access_ctrl_level2_in,
    input wire logic        aux_access_ctrl_level3_in,
    input wire logic        fp_insn_in,
    input wire logic        resp_valid_out,
    input wire logic [63:0] resp_rdata_out,
    input wire logic        resp_fault_out,
    input wire logic        resp_hit_out,
    input wire logic        fp_trap_out,
    input wire logic        fp_vector_trap_bit_out
);
    logic aux_hit; // request decodes to an aux register
    logic gated;   // aux write that needs the gate bits
    assign aux_hit = req_op0_in == STAR_OP0_AUX && req_op1_in == STAR_OP1_AUX
        && req_crn_in == STAR_CRN_AUX && ((req_crm_in == STAR_CRM_AUX_LOW
        && req_op2_in inside {STAR_OP2_ONE, STAR_OP2_TWO, STAR_OP2_THREE})
        || (req_crm_in == STAR_CRM_AUX_FIVE && req_op2_in == STAR_OP2_FIVE));
    assign gated = aux_hit && req_write_in
        && !(req_crm_in == STAR_CRM_AUX_LOW && req_op2_in == STAR_OP2_ONE);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_answer_next: assert property (req_valid_in |=> resp_valid_out)
        else $error("no answer one cycle after request");
    a_no_stray: assert property (!req_valid_in |=> !resp_valid_out)
        else $error("answer without request");
    a_trap_gate: assert property (
        fp_trap_out == (fp_vector_trap_bit_out && fp_insn_in))
        else $error("fp trap differs from bit and insn");
    a_aux_decode: assert property (
        req_valid_in && aux_hit |=> resp_hit_out)
        else $error("aux encoding not claimed");
    a_el0_refused: assert property (
        req_valid_in && aux_hit && cur_level_in == STAR_EL0
        |=> resp_fault_out)
        else $error("aux access from level 0 granted");
    a_el3_granted: assert property (
        req_valid_in && aux_hit && cur_level_in == STAR_EL3
        |=> !resp_fault_out)
        else $error("aux access from level 3 refused");
    a_gate_blocks: assert property (
        req_valid_in && gated && cur_level_in == STAR_EL1
        && !(aux_access_ctrl_level2_in && aux_access_ctrl_level3_in)
        |=> resp_fault_out)
        else $error("ungated level 1 aux write granted");
    a_gate_level2: assert property (
        req_valid_in && gated && cur_level_in == STAR_EL2
        && !aux_access_ctrl_level3_in |=> resp_fault_out)
        else $error("ungated level 2 aux write granted");
    a_fault_quiet: assert property (
        resp_fault_out |-> resp_rdata_out == 64'h0
        && $stable(fp_vector_trap_bit_out))
        else $error("refused access leaked data or state");
    a_trap_held: assert property (
        !(req_valid_in && req_write_in) |=> $stable(fp_vector_trap_bit_out))
        else $error("trap bit moved without write");
    a_trap_reset: assert property (disable iff (1'b0)
        rst_in |=> !fp_vector_trap_bit_out)
        else $error("trap bit not cleared by reset");
    c_fault: cover property (resp_valid_out && resp_fault_out);
    c_trap: cover property (fp_trap_out);
    c_back2back: cover property (req_valid_in [*2]);
endmodule // star_bank_assertions
bind star_bank star_bank_assertions star_bank_assertions_inst (.clock_in,
    .rst_in, .req_valid_in, .req_write_in, .req_op0_in, .req_op1_in,
    .req_crn_in, .req_crm_in, .req_op2_in, .cur_level_in,
    .aux_access_ctrl_level2_in, .aux_access_ctrl_level3_in, .fp_insn_in,
    .resp_valid_out, .resp_rdata_out, .resp_fault_out, .resp_hit_out,
    .fp_trap_out, .fp_vector_trap_bit_out);

// *** bench/tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
    import star_pkg::*;
    localparam logic [8:0] AUX_HI = {STAR_OP0_AUX, STAR_OP1_AUX, STAR_CRN_AUX};
    logic        clock_in, rst_in, rv, rf, rh, trap, tbit, ns, gt, hh, g2, g3;
    logic        fp, req_valid, req_write;
    logic [1:0]  level;     // exception level
    logic [15:0] enc;       // request encoding
    logic [63:0] wdata, rd; // write and read data
    logic [63:0] shadow [5]; // expected contents, trap register last
    int          n_errors, n_compared;
    star_core_model star_core_model_inst (.clock_in(clock_in),
        .valid_out(req_valid), .write_out(req_write), .enc_out(enc),
        .wdata_out(wdata));
    star_bank star_bank_inst (.clock_in(clock_in), .rst_in(rst_in),
        .req_valid_in(req_valid), .req_write_in(req_write),
        .req_op0_in(enc[15:14]), .req_op1_in(enc[13:11]),
        .req_crn_in(enc[10:7]), .req_crm_in(enc[6:3]), .req_op2_in(enc[2:0]),
        .req_wdata_in(wdata), .cur_level_in(level),
        .nonsecure_state_bit_in(ns), .general_trap_select_in(gt),
        .host_hypervisor_select_in(hh), .aux_access_ctrl_level2_in(g2),
        .aux_access_ctrl_level3_in(g3), .fp_insn_in(fp),
        .resp_valid_out(rv), .resp_rdata_out(rd), .resp_fault_out(rf),
        .resp_hit_out(rh), .fp_trap_out(trap), .fp_vector_trap_bit_out(tbit));
    // encoding of aux one, two, three, five, then trap register
    function automatic logic [15:0] enc_of(int i);
        case (i)
            0: return {AUX_HI, STAR_CRM_AUX_LOW, STAR_OP2_ONE};
            1: return {AUX_HI, STAR_CRM_AUX_LOW, STAR_OP2_TWO};
            2: return {AUX_HI, STAR_CRM_AUX_LOW, STAR_OP2_THREE};
            3: return {AUX_HI, STAR_CRM_AUX_FIVE, STAR_OP2_FIVE};
            default: return {STAR_OP0_TRAP, STAR_OP1_TRAP, STAR_CRN_TRAP,
                             STAR_CRM_TRAP, STAR_OP2_TRAP};
        endcase
    endfunction
    // expected permission from level, state and gate bits
    function automatic bit ok(int i, bit w);
        if (i == 4) return level == STAR_EL3;
        if (level == STAR_EL0 || (level == STAR_EL1 && ns && gt)) return 0;
        if (level == STAR_EL2 && !ns) return 0;
        if (w && i > 0 && level == STAR_EL1) return g2 && g3;
        if (w && i > 0 && level == STAR_EL2) return g3;
        return 1;
    endfunction
    // one access, response checked against the shadow copy
    task automatic acc(int i, bit w, logic [63:0] d);
        bit a;
        a = ok(i, w);
        star_core_model_inst.issue(w, enc_of(i), d);
        `CHK(rv, 1'b1)
        `CHK(rf, !a)
        `CHK(rh, 1'b1)
        `CHK(rd, (w || !a) ? 64'h0 : shadow[i])
        if (a && w) shadow[i] = (i == 4) ? {53'h0, d[10], 10'h0} : d;
    endtask
    // verdict and end of run
    task automatic stop_test();
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // free-running core clock
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    // watchdog cuts a hang short
    initial begin
        #40000;
        n_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        {rst_in, level, ns, gt, hh, g2, g3, fp} = 9'h1c0;
        foreach (shadow[k]) shadow[k] = 64'h0;
        void'($urandom(32'h337d));
        repeat (3) @(posedge clock_in);
        #1 rst_in = 1'b0;
        `CHK(tbit, 1'b0)
        for (int i = 0; i < 5; i++) acc(i, 0, 64'h0);
        for (int i = 0; i < 4; i++) acc(i, 1, {$urandom, $urandom});
        ns = 1'b1;
        for (int i = 0; i < 4; i++) acc(i, 0, 64'h0);
        repeat (80) begin
            {level, ns, gt, g2, g3, hh, fp} = 8'($urandom);
            acc($urandom_range(0, 4), 1'($urandom), {$urandom, $urandom});
        end
        {level, ns, gt, g2, g3} = 6'h12;
        acc(1, 1, '1);
        acc(0, 1, 64'h5a5a_0000_ffff_1234);
        level = STAR_EL3;
        acc(4, 1, 64'h0010_0400);
        acc(4, 0, 64'h0);
        star_core_model_inst.idle();
        for (int k = 0; k < 32; k++) begin
            {level, ns, gt, fp} = 5'(k);
            #1 `CHK(trap, fp)
            @(posedge clock_in);
            #1;
        end
        // mid-run reset with the trap bit set
        rst_in = 1'b1;
        @(posedge clock_in);
        #1 rst_in = 1'b0;
        `CHK(tbit, 1'b0)
        foreach (shadow[k]) shadow[k] = 64'h0;
        `CHK(rv, 1'b0)
        star_core_model_inst.issue(0, 16'h0, 64'h0);
        `CHK({rv, rh, rf, rd}, {3'h4, 64'h0})
        acc(0, 0, 64'h0);
        star_core_model_inst.idle();
        stop_test();
    end
endmodule // tb
